//--- src/aluft_core.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
// Contract
// - work register reads and writes at location 05h and takes immediates
// - memory to memory moves only pass through the work register
// - alu does add, adc, sub, sbc, daa, logic, rotates, inc, dec, tests
// - alu operations update their arithmetic flags, except rl, rr and mov, which update none
// - flag register at 0ah writable except power-down and timeout flags
// - bit 0 carry: carry out or no borrow; also rotate through carry
// - bit 1 half carry: low nibble carry or no borrow
// - bit 2 zero set when result is zero
// - bit 3 overflow: carry into msb differs from carry out
// - bit 4 power-down cleared at reset or watchdog clear, set by halt
// - bit 5 timeout cleared at reset, watchdog clear, halt; set by timeout
// - flag bits 6 and 7 read zero
// - only program counter is stacked on interrupt or call
// - acknowledge clears global enable, new requests still latch
// - no acknowledge while stack full; serviced after a return
// - overflow sets bit 5 request; acknowledge vectors to 08h, clears flag
// - return from interrupt sets global enable, plain return does not
// - software re-enabling inside a handler allows nesting
// - requests between two ticks are serviced at the second tick; a request flagged in the same clock as that tick waits for the next one
// - irq control at 0bh; request flag holds until serviced or cleared
// - interrupt request wakes the halted core
// - irq control bit 0 is global enable
// - irq control bit 2 is timer enable
module aluft_core
	import aluft_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic [aluft_pkg::ADDR_W-1:0] ADDR_I,
	input wire logic [aluft_pkg::DATA_W-1:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [aluft_pkg::DATA_W-1:0] RDATA_O,
	input wire logic ALU_GO_I,
	input wire aluft_pkg::aluft_op_e ALU_OP_I,
	input wire logic [aluft_pkg::DATA_W-1:0] OPND_I,
	input wire logic DEST_MEM_I,
	input wire logic TEST_ZERO_I,
	output logic [aluft_pkg::DATA_W-1:0] RESULT_O,
	output logic RESULT_VALID_O,
	output logic SKIP_O,
	input wire logic PHASE_TWO_TICK_I,
	input wire logic TIMER_OVF_I,
	input wire logic RETURN_FROM_INTERRUPT_I,
	input wire logic STACK_FULL_I,
	input wire logic HALT_I,
	input wire logic WATCHDOG_CLEAR_I,
	input wire logic WATCHDOG_TIMEOUT_I,
	output logic IRQ_ACK_O,
	output logic [11:0] IRQ_VECTOR_O,
	output logic WAKE_O,
	output logic [aluft_pkg::DATA_W-1:0] WORK_REGISTER_O
);
	logic [7:0] work_q, work_d;
	logic [7:0] flag_q, flag_d;
	logic [7:0] rdata_q, res_q;
	logic rvalid_q, skip_q, ack_q, wake_q;
	logic [7:0] alu_res;
	logic alu_c, alu_hc, alu_ov;
	aluft_fl_e alu_fl;
	logic gie, tie, tf, ack, wake;
	logic wr_work, wr_flag, wr_irq;
	logic [11:0] vec_q;
	logic [7:0] irq_rd, rd_mux;

	// work register is reachable both by this port and by alu destination; flag and irq control by this port only
	assign wr_work = WR_I && (ADDR_I == WORK_ADDR);
	assign wr_flag = WR_I && (ADDR_I == FLAG_ADDR);
	assign wr_irq = WR_I && (ADDR_I == IRQC_ADDR);

	// operand b is the memory byte or immediate; a is always the work register
	aluft_alu u_alu (
		.op_i(ALU_OP_I),
		.a_i(work_q),
		.b_i(OPND_I),
		.carry_i(flag_q[FLG_C]),
		.half_i(flag_q[FLG_HC]),
		.res_o(alu_res),
		.c_o(alu_c),
		.hc_o(alu_hc),
		.ov_o(alu_ov),
		.fl_o(alu_fl)
	);

	aluft_irq u_irq (
		.clk_i(CORE_CLK_I),
		.rst_i(SYS_RST_I),
		.tick_i(PHASE_TWO_TICK_I),
		.ovf_i(TIMER_OVF_I),
		.sw_we_i(wr_irq),
		.sw_d_i(WDATA_I),
		.return_from_interrupt_i(RETURN_FROM_INTERRUPT_I),
		.stack_full_i(STACK_FULL_I),
		.gie_o(gie),
		.tie_o(tie),
		.tf_o(tf),
		.ack_o(ack),
		.wake_o(wake)
	);

	// no flag or work register push path exists; sequencer stacks pc only
	assign IRQ_VECTOR_O = vec_q;

	always_comb begin
		work_d = work_q;
		// memory destination leaves work register alone, so moves go through it
		if (ALU_GO_I && !DEST_MEM_I) begin
			work_d = alu_res;
		end
		if (wr_work) begin
			work_d = WDATA_I;
		end
	end

	always_comb begin
		flag_d = flag_q;
		if (wr_flag) begin
			flag_d[3:0] = WDATA_I[3:0] & FLAG_SW_MASK[3:0];
		end
		if (ALU_GO_I && alu_fl != ALUFT_FL_NONE) begin
			if (alu_fl != ALUFT_FL_C) begin
				flag_d[FLG_Z] = (alu_res == 8'h00);
			end
			if (alu_fl == ALUFT_FL_C || alu_fl == ALUFT_FL_ALL) begin
				flag_d[FLG_C] = alu_c;
			end
			if (alu_fl == ALUFT_FL_ALL) begin
				flag_d[FLG_HC] = alu_hc;
				flag_d[FLG_OV] = alu_ov;
			end
			if (ALU_OP_I == ALUFT_DAA) begin
				flag_d[FLG_Z] = (alu_res == 8'h00);
			end
		end
		if (HALT_I) begin
			flag_d[FLG_PD] = 1'b1;
		end else if (WATCHDOG_CLEAR_I) begin
			flag_d[FLG_PD] = 1'b0;
		end
		if (WATCHDOG_TIMEOUT_I) begin
			flag_d[FLG_TO] = 1'b1;
		end else if (HALT_I || WATCHDOG_CLEAR_I) begin
			flag_d[FLG_TO] = 1'b0;
		end
		flag_d[7:6] = 2'b00;
	end

	assign irq_rd = {2'b00, tf, 2'b00, tie, 1'b0, gie};
	assign rd_mux = (ADDR_I == WORK_ADDR) ? work_q :
		(ADDR_I == FLAG_ADDR) ? flag_q :
		(ADDR_I == IRQC_ADDR) ? irq_rd : 8'h00;

	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			work_q <= 8'h00;
			flag_q <= FLAG_RST;
			rdata_q <= 8'h00;
			res_q <= 8'h00;
			rvalid_q <= 1'b0;
			skip_q <= 1'b0;
			ack_q <= 1'b0;
			wake_q <= 1'b0;
			vec_q <= TIMER_VECTOR;
		end else begin
			work_q <= work_d;
			flag_q <= flag_d;
			rdata_q <= RD_I ? rd_mux : 8'h00;
			res_q <= alu_res;
			rvalid_q <= ALU_GO_I;
			// skip tests look at the result zero condition
			skip_q <= ALU_GO_I && (TEST_ZERO_I == (alu_res == 8'h00));
			ack_q <= ack;
			wake_q <= wake;
			vec_q <= TIMER_VECTOR;
		end
	end

	assign RDATA_O = rdata_q;
	assign RESULT_O = res_q;
	assign RESULT_VALID_O = rvalid_q;
	assign SKIP_O = skip_q;
	assign IRQ_ACK_O = ack_q;
	assign WAKE_O = wake_q;
	assign WORK_REGISTER_O = work_q;

	hi_bits_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		flag_q[7:6] == 2'b00) else $error("flag high bits set");
	pd_prot_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		wr_flag && !HALT_I && !WATCHDOG_CLEAR_I && !WATCHDOG_TIMEOUT_I
		|=> $stable(flag_q[5:4])) else $error("write hit protected flag");
	zero_flag_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		ALU_GO_I && ALU_OP_I == ALUFT_AND && !wr_flag
		|=> flag_q[FLG_Z] == (res_q == 8'h00)) else $error("zero flag wrong");
	halt_pd_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		HALT_I && !WATCHDOG_TIMEOUT_I |=> flag_q[FLG_PD] && !flag_q[FLG_TO])
		else $error("halt flags wrong");
	add_carry_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		ALU_GO_I && ALU_OP_I == ALUFT_ADD && !wr_flag
		|=> flag_q[FLG_C] == (({1'b0, $past(work_q)} + {1'b0, $past(OPND_I)}) > 9'h0ff))
		else $error("carry wrong");
	work_wr_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		wr_work |=> work_q == $past(WDATA_I)) else $error("work write lost");
	mem_dest_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		ALU_GO_I && DEST_MEM_I && !wr_work |=> $stable(work_q))
		else $error("memory result hit work register");
	add_ovf_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		ALU_GO_I && ALU_OP_I == ALUFT_ADD |=> flag_q[FLG_OV] ==
		(($past(work_q[7]) == $past(OPND_I[7])) && (res_q[7] != $past(work_q[7]))))
		else $error("overflow flag wrong");
	to_set_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		WATCHDOG_TIMEOUT_I |=> flag_q[FLG_TO]) else $error("timeout flag missed");
	irq_rd_a: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		RD_I && ADDR_I == IRQC_ADDR |=> (RDATA_O & 8'hda) == 8'h00)
		else $error("unused control bits read nonzero");
endmodule

//--- src/aluft_pkg.sv
package aluft_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam logic [7:0] WORK_ADDR = 8'h05;
	localparam logic [7:0] FLAG_ADDR = 8'h0a;
	localparam logic [7:0] IRQC_ADDR = 8'h0b;
	localparam logic [11:0] TIMER_VECTOR = 12'h008;
	localparam int STACK_DEPTH = 6;
	localparam int FLG_C = 0;
	localparam int FLG_HC = 1;
	localparam int FLG_Z = 2;
	localparam int FLG_OV = 3;
	localparam int FLG_PD = 4;
	localparam int FLG_TO = 5;
	localparam int IRQ_GIE = 0;
	localparam int IRQ_TIE = 2;
	localparam int IRQ_TF = 5;
	localparam logic [7:0] FLAG_SW_MASK = 8'h0f;
	localparam logic [7:0] IRQC_RST = 8'h00;
	localparam logic [7:0] FLAG_RST = 8'h00;
	localparam logic [3:0] OPA_W = 4'h0;
	typedef enum logic [3:0] {
		ALUFT_ADD = 4'h0,
		ALUFT_ADC = 4'h1,
		ALUFT_SUB = 4'h2,
		ALUFT_SBC = 4'h3,
		ALUFT_DAA = 4'h4,
		ALUFT_AND = 4'h5,
		ALUFT_OR = 4'h6,
		ALUFT_XOR = 4'h7,
		ALUFT_CPL = 4'h8,
		ALUFT_RL = 4'h9,
		ALUFT_RR = 4'ha,
		ALUFT_RLC = 4'hb,
		ALUFT_RRC = 4'hc,
		ALUFT_INC = 4'hd,
		ALUFT_DEC = 4'he,
		ALUFT_MOV = 4'hf
	} aluft_op_e;
	typedef enum logic [1:0] {
		ALUFT_FL_NONE = 2'h0,
		ALUFT_FL_Z = 2'h1,
		ALUFT_FL_C = 2'h2,
		ALUFT_FL_ALL = 2'h3
	} aluft_fl_e;
endpackage

//--- src/aluft_alu.sv
`timescale 1ns/1ps
module aluft_alu
	import aluft_pkg::*;
(
	input wire aluft_op_e op_i,
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic carry_i,
	input wire logic half_i,
	output logic [7:0] res_o,
	output logic c_o,
	output logic hc_o,
	output logic ov_o,
	output aluft_fl_e fl_o
);
	logic [8:0] sum9;
	logic [4:0] low5;
	logic [7:0] addend;
	logic cin;
	logic c7;
	logic is_sub;
	logic [8:0] daa9;
	assign is_sub = (op_i == ALUFT_SUB) || (op_i == ALUFT_SBC);
	// subtract as a + ~b + 1, so carry out means no borrow
	assign addend = is_sub ? ~b_i : (op_i == ALUFT_INC ? 8'h01 :
		(op_i == ALUFT_DEC ? 8'hff : b_i));
	assign cin = (op_i == ALUFT_SUB) ? 1'b1 :
		((op_i == ALUFT_ADC || op_i == ALUFT_SBC) ? carry_i : 1'b0);
	assign sum9 = {1'b0, a_i} + {1'b0, addend} + {8'h00, cin};
	assign low5 = {1'b0, a_i[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
	assign c7 = (({1'b0, a_i[6:0]} + {1'b0, addend[6:0]} + {7'h00, cin}) >> 7) != 8'h00;
	assign daa9 = {1'b0, a_i} + {1'b0, (half_i || a_i[3:0] > 4'h9) ? 8'h06 : 8'h00}
		+ {1'b0, (carry_i || a_i > 8'h99) ? 8'h60 : 8'h00};
	always_comb begin
		res_o = sum9[7:0];
		c_o = carry_i;
		hc_o = half_i;
		ov_o = 1'b0;
		fl_o = ALUFT_FL_Z;
		unique case (op_i)
			ALUFT_ADD, ALUFT_ADC, ALUFT_SUB, ALUFT_SBC: begin
				c_o = sum9[8];
				hc_o = low5[4];
				ov_o = c7 ^ sum9[8];
				fl_o = ALUFT_FL_ALL;
			end
			ALUFT_DAA: begin
				res_o = daa9[7:0];
				c_o = daa9[8] | carry_i;
				fl_o = ALUFT_FL_C;
			end
			ALUFT_AND: res_o = a_i & b_i;
			ALUFT_OR: res_o = a_i | b_i;
			ALUFT_XOR: res_o = a_i ^ b_i;
			ALUFT_CPL: res_o = ~a_i;
			ALUFT_RL: begin
				res_o = {a_i[6:0], a_i[7]};
				fl_o = ALUFT_FL_NONE;
			end
			ALUFT_RR: begin
				res_o = {a_i[0], a_i[7:1]};
				fl_o = ALUFT_FL_NONE;
			end
			ALUFT_RLC: begin
				res_o = {a_i[6:0], carry_i};
				c_o = a_i[7];
				fl_o = ALUFT_FL_C;
			end
			ALUFT_RRC: begin
				res_o = {carry_i, a_i[7:1]};
				c_o = a_i[0];
				fl_o = ALUFT_FL_C;
			end
			ALUFT_INC, ALUFT_DEC: res_o = sum9[7:0];
			ALUFT_MOV: begin
				res_o = b_i;
				fl_o = ALUFT_FL_NONE;
			end
		endcase
	end
endmodule

//--- src/aluft_irq.sv
`timescale 1ns/1ps
module aluft_irq
	import aluft_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic ovf_i,
	input wire logic sw_we_i,
	input wire logic [7:0] sw_d_i,
	input wire logic return_from_interrupt_i,
	input wire logic stack_full_i,
	output logic gie_o,
	output logic tie_o,
	output logic tf_o,
	output logic ack_o,
	output logic wake_o
);
	logic gie_q, tie_q, tf_q, ack_q, wake_q, pend_q;
	logic take;
	// request must be latched before the tick that services it
	assign take = tick_i && pend_q && gie_q && tie_q && !stack_full_i && !ack_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gie_q <= 1'b0;
			tie_q <= 1'b0;
			tf_q <= 1'b0;
			pend_q <= 1'b0;
			ack_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			ack_q <= take;
			wake_q <= tf_q;
			pend_q <= tf_q;
			if (sw_we_i) begin
				gie_q <= sw_d_i[IRQ_GIE];
				tie_q <= sw_d_i[IRQ_TIE];
			end
			if (take) gie_q <= 1'b0;
			else if (return_from_interrupt_i) gie_q <= 1'b1;
			// set beats clear from either source
			if (ovf_i) tf_q <= 1'b1;
			else if (take) tf_q <= 1'b0;
			else if (sw_we_i) tf_q <= sw_d_i[IRQ_TF];
		end
	end
	assign gie_o = gie_q;
	assign tie_o = tie_q;
	assign tf_o = tf_q;
	assign ack_o = ack_q;
	assign wake_o = wake_q;
	tf_held_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tf_q && !ovf_i && !take && !sw_we_i |=> tf_q) else $error("request flag dropped");
	ack_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
		stack_full_i |-> !take) else $error("ack with full stack");
	ack_gie_a: assert property (@(posedge clk_i) disable iff (rst_i)
		take |=> !gie_q && ack_q) else $error("enable kept after ack");
	return_from_interrupt_gie_a: assert property (@(posedge clk_i) disable iff (rst_i)
		return_from_interrupt_i && !take |=> gie_q) else $error("return missed enable");
	ovf_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ovf_i |=> tf_q) else $error("overflow lost");
	tick_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tick_i && pend_q && gie_q && tie_q && !stack_full_i && !ack_q && !ovf_i
		|=> ack_q && !tf_q) else $error("pending request not taken at tick");
	wake_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tf_q |=> wake_q) else $error("no wake on request");
endmodule

//--- bench/aluft_seq_model.sv
`timescale 1ns/1ps
module aluft_seq_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ovf_req_i,
	output logic tick_o,
	output logic ovf_o
);
	logic [1:0] ph_q;
	// one tick per four-phase machine cycle, so requests wait up to four clocks
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ph_q <= 2'h0;
			tick_o <= 1'b0;
			ovf_o <= 1'b0;
		end else begin
			ph_q <= ph_q + 2'h1;
			tick_o <= (ph_q == 2'h3);
			ovf_o <= ovf_req_i;
		end
	end
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import aluft_pkg::*;
	logic clk = 0;
	logic rst = 1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] opnd = 8'h00;
	logic wr = 0, rd = 0, go = 0, dmem = 0, full = 0, tz = 1;
	logic skip;
	logic [4:0] ev = 5'h00;
	aluft_op_e op = ALUFT_ADD;
	logic tick, ovf, ack, wake, vld;
	logic [7:0] rdata, res, work;
	logic [11:0] vec;
	int bad_count = 0;
	int comparisons = 0;
	always #20 clk = ~clk;
	aluft_seq_model u_aluft_seq_model (.clk_i(clk), .rst_i(rst), .ovf_req_i(ev[4]),
		.tick_o(tick), .ovf_o(ovf));
	aluft_core u_aluft_core (.CORE_CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .ALU_GO_I(go),
		.ALU_OP_I(op), .OPND_I(opnd), .DEST_MEM_I(dmem), .TEST_ZERO_I(tz),
		.RESULT_O(res), .RESULT_VALID_O(vld), .SKIP_O(skip), .PHASE_TWO_TICK_I(tick),
		.TIMER_OVF_I(ovf), .RETURN_FROM_INTERRUPT_I(ev[3]), .STACK_FULL_I(full),
		.HALT_I(ev[0]), .WATCHDOG_CLEAR_I(ev[1]), .WATCHDOG_TIMEOUT_I(ev[2]),
		.IRQ_ACK_O(ack), .IRQ_VECTOR_O(vec), .WAKE_O(wake), .WORK_REGISTER_O(work));
	task results;
		$display("mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 0;
	endtask
	task rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		@(posedge clk);
		rd <= 0;
		#1 chk(rdata, e);
	endtask
	// events are single-cycle strobes: halt, wd clear, wd timeout, return_from_interrupt, overflow
	task pulse(input int i);
		@(posedge clk);
		ev[i] <= 1;
		@(posedge clk);
		ev[i] <= 0;
	endtask
	task alu(input aluft_op_e o, input logic [7:0] b, input logic d, input logic [7:0] e);
		@(posedge clk);
		go <= 1;
		op <= o;
		opnd <= b;
		dmem <= d;
		@(posedge clk);
		go <= 0;
		dmem <= 0;
		#1 chk(res, e);
		chk(vld, 8'h01);
	endtask
	task wait_ack(input logic e);
		logic seen;
		seen = 0;
		repeat (20) begin
			@(posedge clk);
			#1 if (ack === 1'b1) seen = 1;
		end
		chk(seen, e);
	endtask
	task t_reset;
		rd_reg(FLAG_ADDR, 8'h00);
		rd_reg(IRQC_ADDR, 8'h00);
		chk(wake, 8'h00);
	endtask
	task t_work;
		wr_reg(WORK_ADDR, 8'h12);
		#1 chk(work, 8'h12);
		rd_reg(WORK_ADDR, 8'h12);
		wr_reg(8'h0c, 8'h55);
		rd_reg(8'h0c, 8'h00);
	endtask
	task t_alu;
		wr_reg(WORK_ADDR, 8'h7f);
		alu(ALUFT_ADD, 8'h01, 0, 8'h80);
		rd_reg(FLAG_ADDR, 8'h0a);
		alu(ALUFT_ADD, 8'h80, 0, 8'h00);
		rd_reg(FLAG_ADDR, 8'h0d);
		wr_reg(WORK_ADDR, 8'h10);
		alu(ALUFT_SUB, 8'h01, 0, 8'h0f);
		chk(skip, 8'h00);
		rd_reg(FLAG_ADDR, 8'h01);
		alu(ALUFT_XOR, 8'h0f, 1, 8'h00);
		chk(work, 8'h0f);
		chk(skip, 8'h01);
		rd_reg(FLAG_ADDR, 8'h05);
		@(posedge clk) tz <= 0;
		alu(ALUFT_INC, 8'h00, 0, 8'h10);
		chk(skip, 8'h01);
		rd_reg(FLAG_ADDR, 8'h01);
	endtask
	task t_flags;
		wr_reg(FLAG_ADDR, 8'h00);
		pulse(2);
		rd_reg(FLAG_ADDR, 8'h20);
		wr_reg(FLAG_ADDR, 8'hff);
		rd_reg(FLAG_ADDR, 8'h2f);
		pulse(0);
		rd_reg(FLAG_ADDR, 8'h1f);
		pulse(1);
		rd_reg(FLAG_ADDR, 8'h0f);
	endtask
	task t_irq;
		wr_reg(IRQC_ADDR, 8'h05);
		pulse(4);
		wait_ack(1);
		chk(vec[7:0], 8'h08);
		chk({4'h0, vec[11:8]}, 8'h00);
		rd_reg(IRQC_ADDR, 8'h04);
		pulse(4);
		wait_ack(0);
		rd_reg(IRQC_ADDR, 8'h24);
		// keep the pending flag set while re-enabling, a zero there clears it
		wr_reg(IRQC_ADDR, 8'h25);
		wait_ack(1);
		pulse(3);
		rd_reg(IRQC_ADDR, 8'h05);
	endtask
	task t_full;
		@(posedge clk);
		full <= 1;
		pulse(4);
		wait_ack(0);
		rd_reg(IRQC_ADDR, 8'h25);
		chk(wake, 8'h01);
		@(posedge clk) full <= 0;
		wait_ack(1);
		rd_reg(IRQC_ADDR, 8'h04);
		chk(wake, 8'h00);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 0;
		t_reset();
		t_work();
		t_alu();
		t_flags();
		t_irq();
		t_full();
		results();
	end
	// whole sequence needs well under 500 clocks
	initial begin
		#200000;
		bad_count++;
		results();
	end
endmodule
